/* File: bench/abfc_led_model.sv */
`timescale 1ns/10ps
module abfc_led_model #(
    parameter int STRINGS = 7,
    parameter int THR_CODE = 0
) (
    input wire logic [7:0] target_i, // Boost target, 0.25 V steps
    input wire logic [7:0] need_i, // String voltage, 0.25 V steps
    input wire logic [STRINGS-1:0] open_i, // Broken strings
    input wire logic [STRINGS-1:0] short_i, // Strings with shorted LEDs
    output abfc_pkg::abfc_cmp_s [STRINGS-1:0] cmp_o // Driver comparators
);
    localparam int LOW = 2 + THR_CODE;
    localparam int HIGH = 12 + 4 * THR_CODE;
    int head;

    always_comb begin
        head = 0;
        for (int i = 0; i < STRINGS; i++) begin
            head = open_i[i] ? 0 : int'(target_i) - int'(need_i) + (short_i[i] ? 40 : 0);
            cmp_o[i].below_low = head < LOW;
            cmp_o[i].above_mid = head > LOW + 2;
            cmp_o[i].above_high = head > HIGH;
        end
    end
endmodule

/* File: bench/abfc_top_sva.sv */
`timescale 1ns/10ps
module abfc_top_sva #(
    parameter int STRINGS = 7,
    parameter int SW = 3
) (
    input wire logic ref_clk_i, // Clock
    input wire logic rst_i, // Reset
    input wire logic enable_i, // Enable pin
    input wire logic reg_wr_i, // Write strobe
    input wire logic reg_rd_i, // Read strobe
    input wire logic [7:0] reg_addr_i, // Address
    input wire logic [7:0] reg_wdata_i, // Write data
    input wire logic phase_shifted_dimming_i, // Phase shift on
    input wire logic [STRINGS-1:0] active_i, // Lit strings
    input wire abfc_pkg::abfc_cmp_s [STRINGS-1:0] cmp_i, // Comparators
    input wire logic uv_6v_i, // Below 6 V
    input wire logic uv_3v_i, // Below 3 V
    input wire logic over_current_i, // Overload
    input wire logic temp_150_i, // Too hot
    input wire logic [7:0] boost_target_o, // Target
    input wire logic boost_run_o, // Boost on
    input wire logic led_run_o, // LEDs on
    input wire logic [STRINGS-1:0] excluded_o, // Excluded strings
    input wire logic fault_n_o, // Pin level
    input wire logic fault_oe_o // Pin pulled low
);
    logic [7:0] ctl_q;
    logic [7:0] sp_q;
    logic [1:0] quiet_q;
    logic adp_q;
    logic [4:0] man_code;
    logic [7:0] man_exp;
    logic any_low;
    logic all_mid;
    logic adp_ok;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctl_q <= 8'h00;
            sp_q <= 8'h00;
        end else if (reg_wr_i && reg_addr_i == abfc_pkg::ADDR_CONTROL) begin
            ctl_q <= reg_wdata_i;
        end else if (reg_wr_i && reg_addr_i == abfc_pkg::ADDR_BOOST_SETPOINT) begin
            sp_q <= reg_wdata_i;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            quiet_q <= 2'b00;
            adp_q <= 1'b0;
        end else begin
            quiet_q <= {quiet_q[0], ~reg_wr_i};
            adp_q <= ctl_q[1] && boost_run_o && (&quiet_q);
        end
    end

    always_comb begin
        man_code = (sp_q[4:0] > abfc_pkg::CODE_MAX) ? abfc_pkg::CODE_MAX : sp_q[4:0];
        man_exp = abfc_pkg::VOLT_BASE_Q + {1'b0, man_code, 2'b00};
        any_low = 1'b0;
        all_mid = |(active_i & ~excluded_o);
        for (int i = 0; i < STRINGS; i++) begin
            if (active_i[i] && !excluded_o[i]) begin
                any_low = any_low | cmp_i[i].below_low;
                all_mid = all_mid & cmp_i[i].above_mid;
            end
        end
        adp_ok = adp_q && ctl_q[1] && boost_run_o && !phase_shifted_dimming_i;
    end

    sequence shut_s;
        ##2 (!boost_run_o && !led_run_o);
    endsequence

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    a_pin_only_low: assert property (fault_n_o == 1'b0)
        else $error("fault pin drives high");
    a_oc_shuts_down: assert property ($rose(over_current_i) |-> shut_s)
        else $error("overload did not shut down");
    a_heat_shuts_down: assert property (temp_150_i |-> shut_s)
        else $error("overheat did not shut down");
    a_uv_shuts_down: assert property ((uv_6v_i && uv_3v_i) |-> shut_s)
        else $error("undervoltage did not shut down");
    a_pin_holds: assert property (fault_oe_o && (&quiet_q) && !reg_wr_i && !reg_rd_i
        && !$past(reg_rd_i) |=> fault_oe_o) else $error("fault pin dropped unasked");
    a_manual_target: assert property (!ctl_q[1] && ctl_q[2] && boost_run_o
        && (&quiet_q) |-> boost_target_o == man_exp) else $error("manual target wrong");
    a_raise_cause: assert property (adp_ok && $past(adp_ok)
        && boost_target_o == $past(boost_target_o) + 8'h01
        |-> $past(any_low) || $past(any_low, 2)) else $error("raise without low driver");
    a_lower_cause: assert property (adp_ok && $past(adp_ok)
        && boost_target_o + 8'h01 == $past(boost_target_o)
        |-> $past(all_mid) || $past(all_mid, 2)) else $error("lower without all above mid");
    a_excl_cleared: assert property ($rose(enable_i) |-> ##[1:2] !(|excluded_o))
        else $error("exclusions kept after enable");
endmodule

bind abfc_top abfc_top_sva #(.STRINGS(STRINGS), .SW(SW)) abfc_top_sva_i (.ref_clk_i, .rst_i,
    .enable_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .phase_shifted_dimming_i,
    .active_i, .cmp_i, .uv_6v_i, .uv_3v_i, .over_current_i, .temp_150_i, .boost_target_o,
    .boost_run_o, .led_run_o, .excluded_o, .fault_n_o, .fault_oe_o);

/* File: bench/tb.sv */
`timescale 1ns/10ps
module tb;
    logic ref_clk_i, rst_i, enable_i, reg_wr_i, reg_rd_i;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, boost_target_o, need;
    logic phase_shifted_dimming_i, shift_19k5_i, low_brightness_i;
    logic [2:0] phase_i;
    logic [6:0] active_i, excluded_o, open_m, short_m;
    abfc_pkg::abfc_cmp_s [6:0] cmp_i;
    logic uv_6v_i, uv_3v_i, over_current_i, temp_150_i, temp_130_i;
    logic boost_run_o, led_run_o, fault_n_o, fault_oe_o;
    int fails;
    int samples_checked;

    abfc_top #(.STRINGS(7), .SW(3)) abfc_top_i (.ref_clk_i, .rst_i, .enable_i, .reg_wr_i,
        .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .phase_shifted_dimming_i,
        .shift_19k5_i, .low_brightness_i, .phase_i, .active_i, .cmp_i, .uv_6v_i, .uv_3v_i,
        .over_current_i, .temp_150_i, .temp_130_i, .boost_target_o, .boost_run_o,
        .led_run_o, .excluded_o, .fault_n_o, .fault_oe_o);
    abfc_led_model #(.STRINGS(7), .THR_CODE(0)) abfc_led_model_i (.target_i(boost_target_o),
        .need_i(need), .open_i(open_m), .short_i(short_m), .cmp_o(cmp_i));

    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask

    task automatic obs(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        d = reg_rdata_o;
    endtask

    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(d, exp);
    endtask

    task automatic wait_tgt(input logic [7:0] exp);
        int n;
        n = 0;
        while (boost_target_o !== exp && n < 4000) begin
            obs(1);
            n++;
        end
        chk(boost_target_o, exp);
        if (n >= 4000) summarize();
    endtask

    task automatic t_regs();
        rc(8'h07, 8'h00);
        rc(8'h01, 8'h01);
        wr(8'h02, 8'hff);
        rc(8'h02, 8'h00);
        rc(8'h10, 8'h00);
    endtask

    task automatic t_manual();
        logic [4:0] codes [5] = '{5'h00, 5'h01, 5'h1b, 5'h1c, 5'h1f};
        wr(8'h00, 8'h05);
        foreach (codes[k]) begin
            wr(8'h07, {3'h0, codes[k]});
            obs(3);
            chk(boost_target_o, (codes[k] > 5'h1c) ? 8'h98 : 8'h28 + {1'b0, codes[k], 2'b00});
        end
    endtask

    task automatic t_adapt();
        wr(8'h07, 8'h0a);
        wr(8'h00, 8'h07);
        obs(1);
        chk(boost_target_o, 8'h50);
        wait_tgt(8'h66);
        obs(300);
        chk(boost_target_o, 8'h66);
        cyc(1);
        need <= 8'h5a;
        wait_tgt(8'h5e);
    endtask

    task automatic t_analog();
        logic [7:0] d;
        cyc(1);
        active_i <= 7'h07;
        open_m <= 7'h01;
        wait_tgt(8'h67);
        obs(3);
        chk({7'h00, excluded_o[0]}, 8'h01);
        chk({7'h00, fault_oe_o}, 8'h01);
        rd(8'h02, d);
        chk(d & 8'h01, 8'h01);
        wait_tgt(8'h5e);
        rd(8'h02, d);
        rc(8'h02, 8'h00);
        short_m <= 7'h02;
        obs(5);
        chk({7'h00, fault_oe_o}, 8'h01);
        cyc(1);
        short_m <= 7'h00;
        rc(8'h02, 8'h02);
        obs(3);
        chk({7'h00, fault_oe_o}, 8'h00);
        cyc(1);
        short_m <= 7'h02;
        obs(5);
        chk({7'h00, fault_oe_o}, 8'h00);
        cyc(1);
        short_m <= 7'h00;
        wr(8'h00, 8'h06);
        wr(8'h00, 8'h07);
        rc(8'h02, 8'h00);
        for (int m = 0; m < 4; m++) begin
            wr(8'h01, 8'(m));
            short_m <= 7'h02;
            cyc(5);
            short_m <= 7'h00;
            rc(8'h02, (m % 2 == 1) ? 8'h02 : 8'h00);
        end
        wr(8'h01, 8'h01);
        open_m <= 7'h00;
        active_i <= 7'h01;
    endtask

    task automatic t_protect();
        cyc(1);
        over_current_i <= 1'b1;
        cyc(1);
        over_current_i <= 1'b0;
        obs(2);
        chk({6'h00, fault_oe_o, boost_run_o}, 8'h02);
        rc(8'h02, 8'h08);
        enable_i <= 1'b0;
        cyc(2);
        enable_i <= 1'b1;
        obs(4);
        chk({6'h00, fault_oe_o, boost_run_o}, 8'h01);
        cyc(1);
        temp_150_i <= 1'b1;
        temp_130_i <= 1'b1;
        cyc(1);
        temp_150_i <= 1'b0;
        obs(3);
        chk({6'h00, led_run_o, boost_run_o}, 8'h00);
        cyc(1);
        temp_130_i <= 1'b0;
        obs(4);
        chk({6'h00, led_run_o, boost_run_o}, 8'h03);
        rc(8'h02, 8'h10);
        for (int lv = 0; lv < 2; lv++) begin
            wr(8'h01, (lv == 1) ? 8'h09 : 8'h01);
            uv_6v_i <= 1'b1;
            obs(4);
            chk({7'h00, led_run_o}, (lv == 1) ? 8'h01 : 8'h00);
            cyc(1);
            uv_3v_i <= 1'b1;
            obs(4);
            chk({7'h00, led_run_o}, 8'h00);
            cyc(1);
            uv_6v_i <= 1'b0;
            uv_3v_i <= 1'b0;
            obs(4);
            chk({7'h00, led_run_o}, 8'h01);
            rc(8'h02, 8'h04);
        end
    endtask

    initial begin
        fails = 0;
        samples_checked = 0;
        rst_i = 1'b1;
        enable_i = 1'b1;
        {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = 18'h00000;
        {phase_shifted_dimming_i, shift_19k5_i, low_brightness_i, phase_i} = 6'h00;
        {uv_6v_i, uv_3v_i, over_current_i, temp_150_i, temp_130_i} = 5'h00;
        active_i = 7'h01;
        open_m = 7'h00;
        short_m = 7'h00;
        need = 8'h64;
        cyc(20);
        rst_i <= 1'b0;
        t_regs();
        t_manual();
        t_adapt();
        t_analog();
        t_protect();
        summarize();
    end

    initial begin
        cyc(90000);
        fails++;
        summarize();
    end
endmodule

/* File: hw/abfc_rate_div.sv */
`timescale 1ns/10ps
module abfc_rate_div #(
    parameter int CYCLES = 100
) (
    input wire logic ref_clk_i, // System clock
    input wire logic rst_i,     // Async reset
    output logic tick_o         // One-cycle enable
);
    logic [15:0] cnt_q;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= 16'h0000;
            tick_o <= 1'b0;
        end else if (cnt_q == 16'(CYCLES - 1)) begin
            cnt_q <= 16'h0000;
            tick_o <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
            tick_o <= 1'b0;
        end
    end
endmodule

/* File: hw/abfc_top.sv */
`timescale 1ns/10ps
// Contract
// (R1) Adaptive bit clear: boost target comes from the setpoint register.
// (R2) Code n targets 10 + n volts, codes 0 to 28.
// (R3) Phase-shifted dimming allows per-step voltage, except at 19.5 kHz.
// (R4) Per-phase adaptation only when per-phase disable bit is 0.
// (R5) Learned voltage per string stored; two-bit setup time sets lead.
// (R6) Low = 0.5+0.25n, Mid = Low+0.5, High = 3+n volts.
// (R7) Single string lit: settle driver voltage between Low and Mid.
// (R8) Any active driver below Low raises boost voltage.
// (R9) Lower when all active above Mid, or any in per-phase low brightness.
// (R10) Faults pull fault pin low; backlight bit rising clears register and pin.
// (R11) Fault method: 00 none, 01 analog, 10 digital, 11 both.
// (R12) Analog: others above High while one low flags open, string excluded.
// (R13) Analog: driver above High flags short on that string.
// (R14) Digital open: string at 38 V and hop to neighbour over threshold.
// (R15) Digital short: learned voltage drop with neighbour gap over threshold.
// (R16) Hop threshold: 00 3 V, 01 5 V, 10 7 V, 11 9 V.
// (R17) Fault sets status bit and asserts pin; status read clears indication.
// (R18) Pin asserts once per LED fault type until enable toggles.
// (R19) Host should read status twice and trust only agreeing reads.
// (R20) Under-voltage always watched; shuts down, flags, resumes on recovery.
// (R21) Excessive boost load shuts down and flags over-current.
// (R22) Thermal shutdown at 150 C, resume below 130 C.
// (R23) Adaptive switched on after start begins from the setpoint register.
module abfc_top #(
    parameter int STRINGS = 7,
    parameter int SW = 3
) (
    input wire logic ref_clk_i,                    // 10 MHz clock
    input wire logic rst_i,                        // Async reset
    input wire logic enable_i,                     // Enable pin level
    input wire logic reg_wr_i,                     // Register write strobe
    input wire logic reg_rd_i,                     // Register read strobe
    input wire logic [7:0] reg_addr_i,             // Register address
    input wire logic [7:0] reg_wdata_i,            // Write data
    output logic [7:0] reg_rdata_o,                // Read data, next cycle
    input wire logic phase_shifted_dimming_i,      // Phase-shift dimming on
    input wire logic shift_19k5_i,                 // 19.5 kHz shift selected
    input wire logic low_brightness_i,             // One string lit at a time
    input wire logic [SW-1:0] phase_i,             // Current phase step
    input wire logic [STRINGS-1:0] active_i,       // Strings lit now
    input wire abfc_pkg::abfc_cmp_s [STRINGS-1:0] cmp_i, // Driver comparators
    input wire logic uv_6v_i,                      // Vin below 6 V (hyst)
    input wire logic uv_3v_i,                      // Vin below 3 V (hyst)
    input wire logic over_current_i,               // Boost overload
    input wire logic temp_150_i,                   // Junction at 150 C
    input wire logic temp_130_i,                   // Junction above 130 C
    output logic [7:0] boost_target_o,             // Target, 0.25 V steps
    output logic boost_run_o,                      // Boost allowed
    output logic led_run_o,                        // LED outputs allowed
    output logic [STRINGS-1:0] excluded_o,         // Strings out of regulation
    output logic fault_n_o,                        // Fault pin level, always 0
    output logic fault_oe_o                        // Fault pin pulled low
);
    logic [7:0] setpoint_q, control_q, config_q, level_q, status_q;
    logic [7:0] target_q;
    logic [7:0] learned_q [STRINGS];
    logic [STRINGS-1:0] excl_q;
    logic [4:0] pin_src_q;
    logic [1:0] led_sent_q;
    logic bl_q, en_q, auto_q, thermal_q;
    abfc_pkg::abfc_pwr_e pwr_q;
    logic tick;
    logic [2:0] setup_cnt_q;
    logic [SW-1:0] phase_q;

    abfc_rate_div #(.CYCLES(abfc_pkg::ADJ_CYCLES)) u_div (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .tick_o(tick)
    );

    function automatic logic [7:0] code_to_q(input logic [4:0] code);
        logic [4:0] c;
        c = (code > abfc_pkg::CODE_MAX) ? abfc_pkg::CODE_MAX : code;
        return abfc_pkg::VOLT_BASE_Q + {1'b0, c, 2'b00}; // [R2]
    endfunction

    function automatic logic [7:0] gap(input logic [7:0] a, input logic [7:0] b);
        return (a > b) ? a - b : b - a;
    endfunction

    logic bl_bit, adaptive, boost_en, per_dis, uv_level;
    logic [1:0] method, setup_sel, hop_sel;
    logic [7:0] hop_thr_q;
    assign bl_bit = control_q[abfc_pkg::CTL_BACKLIGHT];
    assign adaptive = control_q[abfc_pkg::CTL_ADAPTIVE];
    assign boost_en = control_q[abfc_pkg::CTL_BOOST_EN];
    assign method = config_q[abfc_pkg::CFG_FAULT_LO +: 2];
    assign per_dis = config_q[abfc_pkg::CFG_PER_PHASE_DIS];
    assign uv_level = config_q[abfc_pkg::CFG_UV_LEVEL];
    assign setup_sel = config_q[abfc_pkg::CFG_SETUP_LO +: 2];
    assign hop_sel = config_q[abfc_pkg::CFG_HOP_LO +: 2];
    // Hop threshold 3 + 2n volts
    assign hop_thr_q = abfc_pkg::HOP_BASE_Q + 8'(hop_sel) * abfc_pkg::HOP_STEP_Q; // [R16]

    // Comparison over simultaneously active, non-excluded strings
    logic [STRINGS-1:0] use_m, low_v, mid_v, high_v;
    logic any_low, all_mid, any_mid, per_phase, analog_en, digital_en;
    logic [STRINGS-1:0] open_hit, short_hit;
    genvar g;
    generate
        for (g = 0; g < STRINGS; g++) begin : g_cmp
            assign use_m[g] = active_i[g] & ~excl_q[g]; // [R12]
            assign low_v[g] = use_m[g] & cmp_i[g].below_low;
            assign mid_v[g] = use_m[g] & cmp_i[g].above_mid;
            assign high_v[g] = use_m[g] & cmp_i[g].above_high;
            // Open: this one low while every other active one is above High
            assign open_hit[g] = analog_en & use_m[g] & cmp_i[g].below_low &
                ((use_m & ~(STRINGS'(1) << g)) != '0) &
                ((use_m & ~(STRINGS'(1) << g) & ~high_v) == '0); // [R12]
            assign short_hit[g] = analog_en & high_v[g] & ~(|open_hit) &
                (use_m & ~high_v) != '0; // [R13]
        end
    endgenerate
    assign any_low = |low_v; // [R8]
    assign all_mid = (use_m != '0) && ((use_m & ~mid_v) == '0);
    assign any_mid = |mid_v;
    // [R3] [R4]
    assign per_phase = phase_shifted_dimming_i & ~shift_19k5_i & ~per_dis;
    assign analog_en = method[0]; // [R11]
    assign digital_en = method[1] & phase_shifted_dimming_i & low_brightness_i; // [R14]

    // Digital hop detection against the previous phase's learned voltage
    logic [SW-1:0] prev_ph;
    logic [7:0] cur_v, prev_v;
    logic dig_open, dig_short, lower;
    assign prev_ph = (phase_i == '0) ? SW'(STRINGS - 1) : phase_i - SW'(1);
    assign cur_v = learned_q[phase_i];
    assign prev_v = learned_q[prev_ph];
    // [R14]
    assign dig_open = digital_en && cur_v >= abfc_pkg::VOLT_MAX_Q &&
        gap(cur_v, prev_v) > hop_thr_q &&
        prev_v + abfc_pkg::NEAR_MAX_Q < abfc_pkg::VOLT_MAX_Q;
    assign dig_short = digital_en && cur_v < prev_v && gap(cur_v, prev_v) > hop_thr_q; // [R15]
    assign lower = (per_phase & low_brightness_i) ? any_mid : all_mid; // [R9] [R7]

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            setpoint_q <= abfc_pkg::SETPOINT_RST;
            control_q <= abfc_pkg::CONTROL_RST;
            config_q <= abfc_pkg::CONFIG_RST;
            level_q <= abfc_pkg::LEVEL_RST;
        end else if (reg_wr_i) begin
            unique case (reg_addr_i)
                abfc_pkg::ADDR_BOOST_SETPOINT: setpoint_q <= reg_wdata_i;
                abfc_pkg::ADDR_CONTROL: control_q <= reg_wdata_i;
                abfc_pkg::ADDR_CONFIG: config_q <= reg_wdata_i;
                abfc_pkg::ADDR_LEVEL: level_q <= reg_wdata_i; // [R6]
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                abfc_pkg::ADDR_BOOST_SETPOINT: reg_rdata_o <= setpoint_q;
                abfc_pkg::ADDR_CONTROL: reg_rdata_o <= control_q;
                abfc_pkg::ADDR_CONFIG: reg_rdata_o <= config_q;
                abfc_pkg::ADDR_STATUS: reg_rdata_o <= status_q;
                abfc_pkg::ADDR_LEVEL: reg_rdata_o <= level_q;
                abfc_pkg::ADDR_ACTUAL: reg_rdata_o <= target_q;
                default: reg_rdata_o <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            bl_q <= 1'b0;
            en_q <= 1'b0;
            auto_q <= 1'b0;
        end else begin
            bl_q <= bl_bit;
            en_q <= enable_i;
            auto_q <= adaptive;
        end
    end

    // Protection state
    logic uv_now, bl_rise, st_rd, en_rise;
    logic [4:0] ev;
    assign uv_now = uv_level ? uv_3v_i : uv_6v_i; // [R20]
    assign bl_rise = bl_bit & ~bl_q;
    assign en_rise = enable_i & ~en_q;
    assign st_rd = reg_rd_i && reg_addr_i == abfc_pkg::ADDR_STATUS;
    assign ev[abfc_pkg::ST_OPEN] = (|open_hit) | dig_open;
    assign ev[abfc_pkg::ST_SHORT] = (|short_hit) | dig_short;
    assign ev[abfc_pkg::ST_UV] = uv_now;
    assign ev[abfc_pkg::ST_OC] = over_current_i;
    assign ev[abfc_pkg::ST_THERMAL] = temp_150_i;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            thermal_q <= 1'b0;
            pwr_q <= abfc_pkg::ABFC_RUN;
        end else begin
            if (temp_150_i) begin
                thermal_q <= 1'b1; // [R22]
            end else if (!temp_130_i) begin
                thermal_q <= 1'b0; // [R22]
            end
            // Overload stays off until the enable pin restarts the device
            unique case (pwr_q)
                abfc_pkg::ABFC_OC_LATCH: if (en_rise) pwr_q <= abfc_pkg::ABFC_RUN;
                default: begin
                    if (over_current_i) begin
                        pwr_q <= abfc_pkg::ABFC_OC_LATCH; // [R21]
                    end else if (uv_now || temp_150_i || thermal_q) begin
                        pwr_q <= abfc_pkg::ABFC_SHUT; // [R20] [R22]
                    end else begin
                        pwr_q <= abfc_pkg::ABFC_RUN;
                    end
                end
            endcase
        end
    end

    // Status bits: set wins over any clear
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            status_q <= 8'h00;
        end else if (st_rd || bl_rise) begin
            status_q <= {3'b000, ev}; // [R17] [R10]
        end else begin
            status_q <= status_q | {3'b000, ev}; // [R17]
        end
    end

    // Pin sources; LED types only once per enable cycle
    logic [4:0] pin_set;
    assign pin_set = ev & ~{3'b000, led_sent_q}; // [R18]
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_src_q <= 5'h00;
            led_sent_q <= 2'b00;
        end else begin
            if (st_rd || bl_rise) begin
                pin_src_q <= pin_set; // [R17] [R10]
            end else begin
                pin_src_q <= pin_src_q | pin_set; // [R10]
            end
            if (en_rise) begin
                led_sent_q <= 2'b00; // [R18]
            end else begin
                led_sent_q <= led_sent_q | ev[1:0]; // [R18]
            end
        end
    end

    // Learned voltages, exclusion and boost target
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            excl_q <= '0;
            target_q <= abfc_pkg::VOLT_BASE_Q;
            phase_q <= '0;
            setup_cnt_q <= 3'h0;
            for (int i = 0; i < STRINGS; i++) learned_q[i] <= abfc_pkg::VOLT_BASE_Q;
        end else begin
            phase_q <= phase_i;
            if (en_rise) begin
                excl_q <= '0;
            end else begin
                excl_q <= excl_q | open_hit; // [R12]
            end
            if (method == abfc_pkg::FAULT_NONE) excl_q <= '0; // [R11]
            if (!adaptive) begin
                target_q <= code_to_q(setpoint_q[4:0]); // [R1]
            end else if (!auto_q) begin
                target_q <= code_to_q(setpoint_q[4:0]); // [R23]
            end else if (per_phase && phase_i != phase_q) begin
                // Store this string's level, move to next after setup lead
                learned_q[phase_q] <= target_q; // [R5]
                setup_cnt_q <= 3'(setup_sel) + 3'(abfc_pkg::SETUP_BASE_CYCLES); // [R5]
            end else if (setup_cnt_q != 3'h0) begin
                setup_cnt_q <= setup_cnt_q - 3'h1;
                if (setup_cnt_q == 3'h1) target_q <= learned_q[phase_i]; // [R5]
            end else if (tick) begin
                if (any_low && target_q < abfc_pkg::VOLT_MAX_Q) begin
                    target_q <= target_q + 8'h01; // [R8]
                end else if (!any_low && lower && target_q > abfc_pkg::VOLT_BASE_Q) begin
                    target_q <= target_q - 8'h01; // [R9] [R7]
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            boost_target_o <= abfc_pkg::VOLT_BASE_Q;
            boost_run_o <= 1'b0;
            led_run_o <= 1'b0;
            excluded_o <= '0;
            fault_n_o <= 1'b0;
            fault_oe_o <= 1'b0;
        end else begin
            boost_target_o <= target_q;
            boost_run_o <= boost_en && pwr_q == abfc_pkg::ABFC_RUN; // [R20] [R21]
            led_run_o <= bl_bit && pwr_q == abfc_pkg::ABFC_RUN; // [R22]
            excluded_o <= excl_q;
            fault_n_o <= 1'b0;
            fault_oe_o <= |pin_src_q; // [R10]
        end
    end
endmodule

/* File: pkg/abfc_pkg.sv */
package abfc_pkg;
    // Register map
    localparam logic [7:0] ADDR_BOOST_SETPOINT = 8'h07;
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_CONFIG = 8'h01;
    localparam logic [7:0] ADDR_STATUS = 8'h02;
    localparam logic [7:0] ADDR_LEVEL = 8'h03;
    localparam logic [7:0] ADDR_ACTUAL = 8'h04;
    localparam logic [7:0] SETPOINT_RST = 8'h00;
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [7:0] CONFIG_RST = 8'h01;
    localparam logic [7:0] LEVEL_RST = 8'h00;
    // Control fields
    localparam int CTL_BACKLIGHT = 0;
    localparam int CTL_ADAPTIVE = 1;
    localparam int CTL_BOOST_EN = 2;
    // Config fields
    localparam int CFG_FAULT_LO = 0;
    localparam int CFG_PER_PHASE_DIS = 2;
    localparam int CFG_UV_LEVEL = 3;
    localparam int CFG_SETUP_LO = 4;
    localparam int CFG_HOP_LO = 6;
    // Status fields
    localparam int ST_OPEN = 0;
    localparam int ST_SHORT = 1;
    localparam int ST_UV = 2;
    localparam int ST_OC = 3;
    localparam int ST_THERMAL = 4;
    // Voltages in 0.25 V steps: code n targets 10 + n volts
    localparam logic [7:0] VOLT_BASE_Q = 8'd40;
    localparam logic [7:0] VOLT_MAX_Q = 8'd152;
    localparam logic [4:0] CODE_MAX = 5'h1c;
    localparam logic [7:0] HOP_BASE_Q = 8'd12;
    localparam logic [7:0] HOP_STEP_Q = 8'd8;
    localparam logic [7:0] NEAR_MAX_Q = 8'd4;
    localparam logic [1:0] FAULT_NONE = 2'h0;
    // Adaptive step period and setup lead time base
    localparam int ADJ_PERIOD_NS = 10000;
    localparam int CLK_PERIOD_NS = 100;
    localparam int ADJ_CYCLES = ADJ_PERIOD_NS / CLK_PERIOD_NS;
    localparam int SETUP_BASE_CYCLES = 4;

    typedef struct packed {
        logic below_low;
        logic above_mid;
        logic above_high;
    } abfc_cmp_s;

    typedef enum logic [1:0] {
        ABFC_RUN = 2'b00,
        ABFC_SHUT = 2'b01,
        ABFC_OC_LATCH = 2'b10
    } abfc_pwr_e;
endpackage
